// ---- verilog/srt_pkg.sv ----
// Package for the slow reference trim and clock monitor block.
// Assumes a 32-bit APB slave reached from the clock generator base address.
package srt_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [3:0]  IDX_COARSE      = 4'h2;
  localparam logic [3:0]  IDX_FINE_MON    = 4'h3;
  localparam logic [3:0]  IDX_STATUS      = 4'h4;
  localparam logic [3:0]  IDX_IRQ_EN      = 4'h5;
  localparam logic [3:0]  IDX_IRQ_CLR     = 4'h6;
  localparam logic [3:0]  IDX_IRQ_STAT    = 4'h7;

  // Field positions
  localparam int          POS_LOL_IE      = 7;
  localparam int          POS_CLK_MON_EN  = 5;
  localparam int          POS_FINE_TRIM   = 0;
  localparam int          POS_LOL_FLAG    = 7;
  localparam int          POS_EV_LOL      = 0;
  localparam int          POS_EV_CLKLOSS  = 1;

  // Reset values
  localparam logic [7:0]  RST_ZERO8       = 8'h00;
  localparam logic [31:0] RST_ZERO32      = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] coarse;
    logic       fine;
  } srt_trim_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } srt_apb_req_t;

  // Word address of a byte address
  function automatic logic [3:0] srt_word_idx(input logic [11:0] addr);
    srt_word_idx = addr[5:2];
  endfunction

endpackage

// ---- verilog/srt_top.sv ----
// Trim and clock supervision registers of the clock generator.
// Assumes APB master in the clk domain; factory trims and events are synchronous.
//
// Summary of operation
// - Decode registers at indices 2h through 7h
// - Coarse trim is eight binary-weighted bits
// - Higher coarse trim value lengthens period
// - Coarse trim loaded from factory outside debug
// - Coarse trim undefined unless factory loaded
// - Fine trim bit 0 lengthens by step
// - Fine trim loaded from factory outside debug
// - Lock-loss interrupt when bit 7 enabled
// - Clock loss reset request when bit 5
// - Bits 6 and 4..1 read zero
// - Lock-loss flag sticky, write one clears
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module srt_top
  import srt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire srt_apb_req_t apb_req,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        debug_active,
  input  wire srt_trim_t   factory_trim,
  input  wire logic        fll_lock_lost,
  input  wire logic        ext_clock_lost,
  output srt_trim_t        osc_trim,
  output logic             lock_loss_irq,
  output logic             clock_loss_reset_req,
  output logic             irq
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       acc;
  logic       wr;
  logic       rd;
  logic [3:0] idx;
  logic       hit;

  assign acc     = apb_req.psel & apb_req.penable;
  assign wr      = acc & apb_req.pwrite;
  assign rd      = acc & ~apb_req.pwrite;
  assign idx     = srt_word_idx(apb_req.paddr);
  // Zero wait states; unmapped indices answer with an error
  assign pready  = 1'b1;
  assign hit     = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:6] == 6'h00) &&
                   ((idx == IDX_COARSE) || (idx == IDX_FINE_MON) || (idx == IDX_STATUS) ||
                    (idx == IDX_IRQ_EN) || (idx == IDX_IRQ_CLR) || (idx == IDX_IRQ_STAT));
  assign pslverr = acc & ~hit;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0] coarse_q;
  logic [7:0] coarse_d;
  logic       fine_q;
  logic       fine_d;
  logic       lol_ie_q;
  logic       lol_ie_d;
  logic       cme_q;
  logic       cme_d;
  logic       rst_seen_q;

  always_comb
  begin
    coarse_d = coarse_q;
    fine_d   = fine_q;
    lol_ie_d = lol_ie_q;
    cme_d    = cme_q;
    // Outside debug, trims load on every reset edge, then once more on the first edge after release
    if ((rst || rst_seen_q) && !debug_active)
    begin
      coarse_d = factory_trim.coarse;
      fine_d   = factory_trim.fine;
    end
    if (wr && hit && idx == IDX_COARSE)
    begin
      coarse_d = apb_req.pwdata[7:0];
    end
    if (wr && hit && idx == IDX_FINE_MON)
    begin
      lol_ie_d = apb_req.pwdata[POS_LOL_IE];
      cme_d    = apb_req.pwdata[POS_CLK_MON_EN];
      fine_d   = apb_req.pwdata[POS_FINE_TRIM];
    end
  end

  // Trims have no reset term: undefined unless factory values load
  always_ff @(posedge clk)
  begin
    coarse_q   <= coarse_d;
    fine_q     <= fine_d;
    rst_seen_q <= rst;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lol_ie_q <= 1'b0;
      cme_q    <= 1'b0;
    end
    else
    begin
      lol_ie_q <= lol_ie_d;
      cme_q    <= cme_d;
    end
  end

  // Oscillator raises period with value; fine bit adds one step
  assign osc_trim.coarse = coarse_q;
  assign osc_trim.fine   = fine_q;

  // ****************************************************************
  // Lock-loss flag and event sticky bits
  // ****************************************************************
  logic       lol_q;
  logic       lol_d;
  logic [1:0] ev_q;
  logic [1:0] ev_d;
  logic [1:0] ev_en_q;
  logic [1:0] ev_en_d;
  logic       clr_lol;

  assign clr_lol = wr && hit && idx == IDX_STATUS && apb_req.pwdata[POS_LOL_FLAG];

  always_comb
  begin
    lol_d   = lol_q;
    ev_d    = ev_q;
    ev_en_d = ev_en_q;
    // Set wins over a same-cycle clear
    if (clr_lol)
    begin
      lol_d = 1'b0;
    end
    if (fll_lock_lost)
    begin
      lol_d = 1'b1;
    end
    if (wr && hit && idx == IDX_IRQ_CLR)
    begin
      ev_d = ev_q & ~apb_req.pwdata[1:0];
    end
    if (fll_lock_lost)
    begin
      ev_d[POS_EV_LOL] = 1'b1;
    end
    if (cme_q && ext_clock_lost)
    begin
      ev_d[POS_EV_CLKLOSS] = 1'b1;
    end
    if (wr && hit && idx == IDX_IRQ_EN)
    begin
      ev_en_d = apb_req.pwdata[1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lol_q   <= 1'b0;
      ev_q    <= 2'h0;
      ev_en_q <= 2'h0;
    end
    else
    begin
      lol_q   <= lol_d;
      ev_q    <= ev_d;
      ev_en_q <= ev_en_d;
    end
  end

  assign lock_loss_irq        = lol_ie_q & lol_q;
  // Combinational so a lost clock still reaches the reset controller
  assign clock_loss_reset_req = cme_q & ext_clock_lost;
  assign irq                  = |(ev_q & ev_en_q);

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb
  begin
    rdata_d = rdata_q;
    if (rd)
    begin
      rdata_d = RST_ZERO32;
      case (idx)
        IDX_COARSE:   rdata_d[7:0] = coarse_q;
        // Bits 6 and 4..1 stay zero
        IDX_FINE_MON: rdata_d[7:0] = {lol_ie_q, 1'b0, cme_q, 4'h0, fine_q};
        IDX_STATUS:   rdata_d[POS_LOL_FLAG] = lol_q;
        IDX_IRQ_EN:   rdata_d[1:0] = ev_en_q;
        IDX_IRQ_STAT: rdata_d[1:0] = ev_q;
        default:      rdata_d = RST_ZERO32;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= RST_ZERO32;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Zero-wait read returns data in the access cycle
  assign prdata = rd ? rdata_d : rdata_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_irq_gate;
    @(posedge clk) disable iff (rst)
      (fll_lock_lost && lol_ie_d) |=> lock_loss_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("lock loss irq mismatch");

  property p_lol_set;
    @(posedge clk) disable iff (rst)
      fll_lock_lost |=> lol_q;
  endproperty
  a_lol_set: assert property (p_lol_set) else $error("lock loss flag not set");

  property p_lol_hold;
    @(posedge clk) disable iff (rst)
      (lol_q && !clr_lol) |=> lol_q;
  endproperty
  a_lol_hold: assert property (p_lol_hold) else $error("lock loss flag lost");

  property p_lol_clr;
    @(posedge clk) disable iff (rst)
      (clr_lol && !fll_lock_lost) |=> !lol_q;
  endproperty
  a_lol_clr: assert property (p_lol_clr) else $error("lock loss flag not cleared");

  property p_mon;
    @(posedge clk) disable iff (rst)
      (!cme_q) |-> !clock_loss_reset_req;
  endproperty
  a_mon: assert property (p_mon) else $error("reset request while monitor off");

  property p_rsvd;
    @(posedge clk) disable iff (rst)
      (rd && idx == IDX_FINE_MON) |-> (prdata[6] == 1'b0 && prdata[4:1] == 4'h0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_coarse_wr;
    @(posedge clk) disable iff (rst)
      (wr && hit && idx == IDX_COARSE) |=> osc_trim.coarse == $past(apb_req.pwdata[7:0]);
  endproperty
  a_coarse_wr: assert property (p_coarse_wr) else $error("coarse trim not written");

  property p_factory;
    @(posedge clk)
      (rst && !debug_active) |=> osc_trim == $past(factory_trim);
  endproperty
  a_factory: assert property (p_factory) else $error("factory trim not loaded");

endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the slow reference trim and clock monitor block.
// Assumes a zero-wait APB slave and registered trim outputs.
`timescale 1ns/1ps
module tb_top
  import srt_pkg::*;
;
  logic         clk;
  logic         rst;
  srt_apb_req_t req;
  logic         pready;
  logic [31:0]  prdata;
  logic         pslverr;
  logic         dbg;
  srt_trim_t    ftrim;
  logic         lol;
  logic         ecl;
  srt_trim_t    otrim;
  logic         lirq;
  logic         creq;
  logic         irq;
  int           n_errors;
  int           checks_done;

  srt_top i_srt_top (
    .clk                  (clk),
    .rst                  (rst),
    .apb_req              (req),
    .pready               (pready),
    .prdata               (prdata),
    .pslverr              (pslverr),
    .debug_active         (dbg),
    .factory_trim         (ftrim),
    .fll_lock_lost        (lol),
    .ext_clock_lost       (ecl),
    .osc_trim             (otrim),
    .lock_loss_irq        (lirq),
    .clock_loss_reset_req (creq),
    .irq                  (irq)
  );

  // ****************************************
  // Clock and tasks
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results();
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", name, e, g);
      n_errors++;
    end
  endtask

  // Sample a settled value just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One APB transfer; waits on pready, bounded so a hang ends the run
  task automatic xfer(input logic [31:0] w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] err);
    int          n;
    logic        rdy;
    logic        got_err;
    logic [31:0] got_data;
    n        = 0;
    rdy      = 1'b0;
    got_err  = 1'b0;
    got_data = 32'h0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w[0];
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    // Answer read mid-cycle, settled for the edge that ends the access
    while (!rdy && n < 20)
    begin
      @(negedge clk);
      rdy      = (pready === 1'b1);
      got_err  = pslverr;
      got_data = prdata;
      n++;
      @(posedge clk);
    end
    if (!rdy)
    begin
      n_errors++;
      results();
    end
    chk("pslverr", err, {31'h0, got_err});
    if (!w[0])
      chk("prdata", e, got_data);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_errors    = 0;
    checks_done = 0;
    req         = '0;
    rst         = 1'b1;
    dbg         = 1'b0;
    ftrim       = {8'ha5, 1'b1};
    lol         = 1'b0;
    ecl         = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk("osc_trim", {23'h0, 8'ha5, 1'b1}, {23'h0, otrim});
    xfer(0, 12'h008, 0, 32'ha5, 0);
    xfer(1, 12'h00c, 32'hff, 0, 0);
    xfer(0, 12'h00c, 0, 32'ha1, 0);
    xfer(1, 12'h008, 32'h5a, 0, 0);
    tick(1);
    chk("osc_trim", {23'h0, 8'h5a, 1'b1}, {23'h0, otrim});
    xfer(0, 12'h008, 0, 32'h5a, 0);
    xfer(1, 12'h00c, 32'h00, 0, 0);
    ecl <= 1'b1;
    tick(2);
    chk("reset_req", 0, {31'h0, creq});
    xfer(1, 12'h00c, 32'h20, 0, 0);
    tick(1);
    chk("reset_req", 1, {31'h0, creq});
    @(posedge clk);
    ecl <= 1'b0;
    tick(1);
    chk("reset_req", 0, {31'h0, creq});
    xfer(0, 12'h01c, 0, 32'h2, 0);
    xfer(1, 12'h014, 32'h2, 0, 0);
    tick(1);
    chk("irq", 1, {31'h0, irq});
    xfer(1, 12'h014, 32'h0, 0, 0);
    tick(1);
    chk("irq", 0, {31'h0, irq});
    xfer(1, 12'h018, 32'h2, 0, 0);
    xfer(0, 12'h01c, 0, 32'h0, 0);
    xfer(1, 12'h014, 32'h1, 0, 0);
    // Lock lost with its interrupt disabled: flag yes, request no
    @(posedge clk);
    lol <= 1'b1;
    @(posedge clk);
    lol <= 1'b0;
    tick(1);
    chk("lock_irq", 0, {31'h0, lirq});
    chk("irq", 1, {31'h0, irq});
    xfer(0, 12'h010, 0, 32'h80, 0);
    xfer(1, 12'h00c, 32'h80, 0, 0);
    tick(1);
    chk("lock_irq", 1, {31'h0, lirq});
    xfer(1, 12'h010, 32'h00, 0, 0);
    xfer(0, 12'h010, 0, 32'h80, 0);
    xfer(1, 12'h010, 32'h80, 0, 0);
    xfer(0, 12'h010, 0, 32'h00, 0);
    tick(1);
    chk("lock_irq", 0, {31'h0, lirq});
    // Lock lost with its interrupt enabled: request follows the flag
    @(posedge clk);
    lol <= 1'b1;
    @(posedge clk);
    lol <= 1'b0;
    tick(1);
    chk("lock_irq", 1, {31'h0, lirq});
    xfer(1, 12'h018, 32'h1, 0, 0);
    tick(1);
    chk("irq", 0, {31'h0, irq});
    xfer(0, 12'h020, 0, 32'h0, 1);
    xfer(1, 12'h002, 32'hff, 0, 1);
    // Reset under debug keeps the written trim
    @(posedge clk);
    rst   <= 1'b1;
    dbg   <= 1'b1;
    ftrim <= {8'h11, 1'b1};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    chk("osc_trim", {23'h0, 8'h5a, 1'b0}, {23'h0, otrim});
    xfer(0, 12'h00c, 0, 32'h00, 0);
    results();
  end
endmodule
